// file: include/bcsu_cfg.svh
`ifndef BCSU_CFG_SVH
`define BCSU_CFG_SVH
// Purpose: constants of the bus command and status unit
// Assumes: 10 MHz clk, byte-wide listener and talker handshakes
// Notes: offsets of codes in the entry memory follow bcsu_val_t
// Function
// - hold front panel bus address, default 13
// - value codes act only after enter code
// - learn dump ascii, 64 chars, end flag
// - learn dump binary, 30 bytes, end flag
// - identify query returns id text, end flag
// - status text query sends 23 chars
// - mask readback sends one binary byte
// - status byte weights fixed, 32/128 zero
// - mask prefix then one byte stores mask
// - request flag only from enabled conditions
// - condition bits stay set until cleared
// - group trigger ignored, immediate or delayed
// - decode six measurement mode codes
// - limit check on/off gates limit condition
// - reference cal factor 50.0 to 120.0
// - negative external, positive internal reference
// - local key returns local unless locked
// - bus subsets fixed, no controller capability
// - clear code clears status and request
// - mask cleared at power on
`define BCSU_ADDR_RST 5'h0d
`define BCSU_MASK_RST 8'h00
`define BCSU_CLK_NS 100
`define BCSU_SETTLE_NS 100000
`define BCSU_SETTLE_CYC (`BCSU_SETTLE_NS / `BCSU_CLK_NS)
`define BCSU_LP1_LEN 7'h40
`define BCSU_LP2_LEN 7'h1e
`define BCSU_SM_LEN 7'h17
`define BCSU_RV_LEN 7'h01
`define BCSU_ID_LEN 7'h0c
`define BCSU_CAL_MIN 16'h01f4
`define BCSU_CAL_MAX 16'h04b0
`define BCSU_KB_MIN 16'h000a
`define BCSU_KB_MAX 16'h05dc
`define BCSU_NUM_CAP 16'h1999
`define BCSU_SB_LIMIT 4
`define BCSU_SB_RQS 6
`endif

// file: include/bcsu_pkg.sv
// Purpose: types of the bus command and status unit
// Assumes: nothing beyond SystemVerilog enums
// Notes: state codes are written out
package bcsu_pkg;
  typedef enum logic [2:0] {
    BCSU_M_A = 3'h0, BCSU_M_B = 3'h1, BCSU_M_AMB = 3'h2,
    BCSU_M_BMA = 3'h3, BCSU_M_AOB = 3'h4, BCSU_M_BOA = 3'h5
  } bcsu_mode_t;
  typedef enum logic [1:0] {
    P_IDLE = 2'h0, P_SEC = 2'h1, P_SUF = 2'h2, P_MASK = 2'h3
  } bcsu_pst_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'h0, T_FETCH = 2'h1, T_LOAD = 2'h2, T_SEND = 2'h3
  } bcsu_tst_t;
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0, SRC_LP1 = 3'h1, SRC_LP2 = 3'h2,
    SRC_ID = 3'h3, SRC_SM = 3'h4, SRC_RV = 3'h5
  } bcsu_src_t;
  typedef enum logic [3:0] {
    V_NONE = 4'h0, V_CL = 4'h1, V_KB = 4'h2, V_LL = 4'h3, V_LH = 4'h4,
    V_OS = 4'h5, V_ST = 4'h6, V_RC = 4'h7, V_RM = 4'h8, V_FM = 4'h9
  } bcsu_val_t;
  typedef enum logic [1:0] {
    GET_IGNORE = 2'h0, GET_NOW = 2'h1, GET_DELAY = 2'h2
  } bcsu_get_t;
endpackage : bcsu_pkg

// file: hw/bcsu_word_mem.sv
// Purpose: entry value store for the command unit
// Assumes: one write and one read port on clk
// Notes: read data is registered, one cycle of latency
`timescale 1ns/1ns
module bcsu_word_mem #(
  parameter int AW = 4,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule : bcsu_word_mem

// file: hw/bcsu_top.sv
// Purpose: program code interpreter, talker data and status byte
// Assumes: bus handshakes done outside; one byte per rx_valid pulse
// Notes: serial poll byte and parallel poll bit are driven from here
`timescale 1ns/1ns
`include "bcsu_cfg.svh"
module bcsu_top #(
  parameter int SETTLE_CYC = `BCSU_SETTLE_CYC,
  parameter logic [95:0] ID_TEXT = "PWRMTRV01.00" // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic talk_addressed,
  input wire logic tx_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic tx_eoi,
  input wire logic spoll_active,
  output logic [7:0] status_byte,
  output logic srq_out,
  output logic ppoll_bit,
  input wire logic get_cmd,
  input wire logic ren_listen,
  input wire logic gtl_cmd,
  input wire logic lockout,
  input wire logic local_key_pin,
  output logic remote_mode,
  input wire logic addr_entry_mode,
  input wire logic [4:0] fp_addr,
  input wire logic fp_addr_load,
  output logic [4:0] bus_addr,
  input wire logic data_ready_evt,
  input wire logic calzero_evt,
  input wire logic meas_err_evt,
  input wire logic limit_evt,
  output bcsu_pkg::bcsu_mode_t meas_mode,
  output logic limit_check_en,
  output logic trig_out,
  output logic cal_start,
  output logic cal_external,
  output logic [15:0] cal_value,
  output logic entry_load,
  output bcsu_pkg::bcsu_val_t entry_code,
  output logic [15:0] entry_value
);
  import bcsu_pkg::*;

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_ch

  function automatic logic [15:0] mul10(input logic [15:0] n,
                                        input logic [3:0] d);
    logic [19:0] t;
    t = {n, 3'h0} + {2'h0, n, 1'h0} + {16'h0, d};
    mul10 = t[15:0];
  endfunction : mul10

  function automatic logic [6:0] src_len(input bcsu_src_t s);
    unique case (s)
      SRC_LP1: src_len = `BCSU_LP1_LEN;
      SRC_LP2: src_len = `BCSU_LP2_LEN;
      SRC_ID: src_len = `BCSU_ID_LEN;
      SRC_SM: src_len = `BCSU_SM_LEN;
      SRC_RV: src_len = `BCSU_RV_LEN;
      default: src_len = 7'h01;
    endcase
  endfunction : src_len

  bcsu_pst_t pst_r;
  bcsu_tst_t tst_r;
  bcsu_src_t src_r;
  bcsu_val_t pend_r;
  bcsu_get_t get_r;
  bcsu_mode_t mode_r;
  logic [15:0] pair_r, num_r, cal_r, ev_val_r;
  logic [7:0] c1_r, mask_r, tx_r;
  logic [4:0] stat_r, pend_ev_r, addr_r;
  logic [1:0] frac_r;
  logic [6:0] idx_r;
  logic [11:0] dly_r;
  logic neg_r, dig_r, lim_r, last_r, spoll_d_r, remote_r, trig_r;
  logic cal_go_r, cal_ext_r, ev_load_r;
  logic lk_s1_r, lk_s2_r, lk_s3_r;
  logic [15:0] mem_rd;

  // byte classes and code decode
  wire [15:0] pair_w = {c1_r, rx_byte};
  wire [23:0] trip_w = {pair_r, rx_byte};
  wire is_dig = rx_byte >= "0" && rx_byte <= "9";
  wire [3:0] dig_w = rx_byte[3:0];
  wire is_sep = rx_byte == " " || rx_byte == "," || rx_byte == ";" ||
                rx_byte == 8'h0d || rx_byte == 8'h0a;
  wire is_num = is_dig || rx_byte == "." || rx_byte == "-" ||
                rx_byte == "+";
  wire in_idle = rx_valid && pst_r == P_IDLE;
  wire in_sec = rx_valid && pst_r == P_SEC;
  wire in_suf = rx_valid && pst_r == P_SUF;
  wire in_mask = rx_valid && pst_r == P_MASK;
  wire pr_mode = pair_w == "AP" || pair_w == "BP" || pair_w == "AD" ||
                 pair_w == "BD" || pair_w == "AR" || pair_w == "BR";
  wire pr_sfx = pair_w == "GT" || pair_w == "LM" || pair_w == "LP" ||
                pair_w == "TR" || pair_w == "RL" || pair_w == "OC" ||
                pair_w == "?I";
  wire pr_nop = pair_w == "AE" || pair_w == "BE" || pair_w == "DA" ||
                pair_w == "DD" || pair_w == "DE" || pair_w == "DO" ||
                pair_w == "FA" || pair_w == "FH" || pair_w == "LG" ||
                pair_w == "LN" || pair_w == "PR" || pair_w == "RA" ||
                pair_w == "RH" || pair_w == "ZE";
  bcsu_val_t val_w;
  always_comb begin
    unique case (pair_w)
      "CL": val_w = V_CL;
      "KB": val_w = V_KB;
      "LL": val_w = V_LL;
      "LH": val_w = V_LH;
      "OS": val_w = V_OS;
      "ST": val_w = V_ST;
      "RC": val_w = V_RC;
      "RM": val_w = V_RM;
      "FM": val_w = V_FM;
      default: val_w = V_NONE;
    endcase
  end
  wire cs_p = in_sec && pair_w == "CS";
  wire en_p = in_sec && pair_w == "EN";
  wire known = pr_mode || pr_sfx || pr_nop || val_w != V_NONE ||
               pair_w == "CS" || pair_w == "EN" || pair_w == "SM" ||
               pair_w == "RV" || pair_w == "@1";
  wire sd_lo2 = rx_byte >= "0" && rx_byte <= "2";
  wire sd_lo1 = rx_byte == "0" || rx_byte == "1";
  wire suf_ok = (pair_r == "GT" && sd_lo2) || (pair_r == "LM" && sd_lo1) ||
                (pair_r == "LP" && (rx_byte == "1" || rx_byte == "2")) ||
                (pair_r == "TR" && rx_byte >= "0" && rx_byte <= "3") ||
                (pair_r == "RL" && sd_lo1) || (pair_r == "OC" && sd_lo1) ||
                trip_w == "?ID";
  // entry value in tenths of a percent
  wire [15:0] ent_w = (frac_r == 2'h2) ? num_r : mul10(num_r, 4'h0);
  wire cl_in = ent_w >= `BCSU_CAL_MIN && ent_w <= `BCSU_CAL_MAX;
  wire kb_in = ent_w >= `BCSU_KB_MIN && ent_w <= `BCSU_KB_MAX;
  wire en_val = en_p && pend_r != V_NONE;
  wire range_bad = en_val && dig_r &&
                   ((pend_r == V_CL && !cl_in) ||
                    (pend_r == V_KB && !kb_in));
  wire cl_go = en_val && pend_r == V_CL && !range_bad;
  wire val_ok = en_val && !range_bad;
  wire err_p = (in_sec && !known) || (in_suf && !suf_ok) ||
               range_bad;

  // parser state and numeric entry
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_r <= P_IDLE;
      c1_r <= 8'h00;
      pair_r <= 16'h0000;
    end else if (rx_valid) begin
      c1_r <= rx_byte;
      unique case (pst_r)
        P_IDLE: pst_r <= (is_num || is_sep) ? P_IDLE : P_SEC;
        P_SEC: begin
          pair_r <= pair_w;
          pst_r <= pair_w == "@1" ? P_MASK : (pr_sfx ? P_SUF : P_IDLE);
        end
        P_SUF, P_MASK: pst_r <= P_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      num_r <= 16'h0000;
      frac_r <= 2'h0;
      neg_r <= 1'b0;
      dig_r <= 1'b0;
      pend_r <= V_NONE;
    end else if (in_sec && (val_w != V_NONE || pair_w == "EN")) begin
      pend_r <= val_w;
      num_r <= 16'h0000;
      frac_r <= 2'h0;
      neg_r <= 1'b0;
      dig_r <= 1'b0;
    end else if (in_idle && is_num) begin
      if (rx_byte == "-" || rx_byte == "+") begin
        neg_r <= rx_byte == "-";
      end else if (rx_byte == ".") begin
        frac_r <= (frac_r == 2'h0) ? 2'h1 : frac_r;
      end else if (frac_r != 2'h2 && num_r < `BCSU_NUM_CAP) begin
        // one fraction digit kept, later ones dropped
        num_r <= mul10(num_r, dig_w);
        frac_r <= (frac_r == 2'h1) ? 2'h2 : frac_r;
        dig_r <= 1'b1;
      end
    end
  end

  // settings steered by codes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= BCSU_M_A;
      lim_r <= 1'b0;
      get_r <= GET_IGNORE;
      mask_r <= `BCSU_MASK_RST;
    end else begin
      if (in_sec && pr_mode) begin
        unique case (pair_w)
          "AP": mode_r <= BCSU_M_A;
          "BP": mode_r <= BCSU_M_B;
          "AD": mode_r <= BCSU_M_AMB;
          "BD": mode_r <= BCSU_M_BMA;
          "AR": mode_r <= BCSU_M_AOB;
          default: mode_r <= BCSU_M_BOA;
        endcase
      end
      if (in_suf && pair_r == "LM" && suf_ok) begin
        lim_r <= rx_byte[0];
      end
      if (in_suf && pair_r == "GT" && suf_ok) begin
        get_r <= bcsu_get_t'(rx_byte[1:0]);
      end
      if (in_mask) begin
        mask_r <= rx_byte;
      end
    end
  end

  // calibration start and entry load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_r <= 16'h03e8;
      cal_go_r <= 1'b0;
      cal_ext_r <= 1'b0;
      ev_load_r <= 1'b0;
      ev_val_r <= 16'h0000;
    end else begin
      cal_go_r <= cl_go;
      ev_load_r <= val_ok;
      if (val_ok) begin
        ev_val_r <= dig_r ? ent_w : 16'h0000;
      end
      if (cl_go && dig_r) begin
        // empty entry recalibrates with the last value
        cal_r <= ent_w;
        cal_ext_r <= neg_r;
      end
    end
  end

  bcsu_word_mem #(.AW(4), .DW(16)) u_mem (
    .clk(clk),
    .we(val_ok),
    .waddr(pend_r),
    .wdata({neg_r, ent_w[14:0]}),
    .raddr(src_r == SRC_LP1 ? idx_r[5:2] : idx_r[4:1]),
    .rdata_r(mem_rd)
  );

  // status byte, frozen while a serial poll runs except that a clear code still clears it
  wire [4:0] ev_w = {limit_evt & lim_r, meas_err_evt, err_p,
                     calzero_evt, data_ready_evt};
  wire poll_end = spoll_d_r && !spoll_active;
  wire [4:0] stat_base = (cs_p || poll_end) ? 5'h00 : stat_r;
  wire [4:0] stat_nxt = spoll_active ? (cs_p ? 5'h00 : stat_r) :
                        (stat_base | ev_w | pend_ev_r);
  wire [4:0] pend_nxt = spoll_active ?
                        ((cs_p ? 5'h00 : pend_ev_r) | ev_w) : 5'h00;
  wire request_service_flag = |(stat_r & mask_r[4:0]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= 5'h00;
      pend_ev_r <= 5'h00;
      spoll_d_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      pend_ev_r <= pend_nxt;
      spoll_d_r <= spoll_active;
    end
  end

  // talker: fetch, load byte, hold until taken
  wire [6:0] len_w = src_len(src_r);
  wire [3:0] nib_w = mem_rd[{2'h3 - idx_r[1:0], 2'h0} +: 4];
  wire [7:0] sm_w [0:12];
  assign sm_w[0] = "S";
  assign sm_w[1] = "M";
  assign sm_w[2] = hex_ch(status_byte[7:4]);
  assign sm_w[3] = hex_ch(status_byte[3:0]);
  assign sm_w[4] = ",";
  assign sm_w[5] = hex_ch(mask_r[7:4]);
  assign sm_w[6] = hex_ch(mask_r[3:0]);
  assign sm_w[7] = ",";
  assign sm_w[8] = hex_ch({1'b0, mode_r});
  assign sm_w[9] = ",";
  assign sm_w[10] = hex_ch({3'h0, lim_r});
  assign sm_w[11] = ",";
  assign sm_w[12] = hex_ch({2'h0, get_r});
  wire [7:0] sm_ch = idx_r < 7'h0d ? sm_w[idx_r[3:0]] :
                     (idx_r == 7'h15 ? 8'h0d :
                     (idx_r == 7'h16 ? 8'h0a : " "));
  wire [7:0] byte_w =
    src_r == SRC_LP1 ? hex_ch(nib_w) :
    src_r == SRC_LP2 ? (idx_r[0] ? mem_rd[7:0] : mem_rd[15:8]) :
    src_r == SRC_ID ? ID_TEXT[{3'h0, 7'h0b - idx_r} * 8 +: 8] :
    src_r == SRC_SM ? sm_ch : mask_r;
  wire tx_take = tst_r == T_SEND && tx_ready;
  wire new_src = (in_sec && (pair_w == "SM" || pair_w == "RV")) ||
                 (in_suf && suf_ok && (pair_r == "LP" || pair_r == "?I"));
  bcsu_src_t src_w;
  assign src_w = pair_w == "SM" ? SRC_SM : pair_w == "RV" ? SRC_RV :
                 pair_r == "?I" ? SRC_ID :
                 (rx_byte == "1" ? SRC_LP1 : SRC_LP2);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tst_r <= T_IDLE;
      src_r <= SRC_NONE;
      idx_r <= 7'h00;
      tx_r <= 8'h00;
      last_r <= 1'b0;
    end else if (new_src && tst_r == T_IDLE) begin
      src_r <= src_w;
    end else if (tst_r != T_IDLE && !talk_addressed) begin
      tst_r <= T_IDLE;
      src_r <= SRC_NONE;
    end else begin
      unique case (tst_r)
        T_IDLE: if (src_r != SRC_NONE && talk_addressed) begin
          tst_r <= T_FETCH;
          idx_r <= 7'h00;
        end
        T_FETCH: tst_r <= T_LOAD;
        T_LOAD: begin
          tx_r <= byte_w;
          last_r <= idx_r == len_w - 7'h01;
          tst_r <= T_SEND;
        end
        T_SEND: if (tx_ready) begin
          tst_r <= last_r ? T_IDLE : T_FETCH;
          src_r <= last_r ? SRC_NONE : src_r;
          idx_r <= idx_r + 7'h01;
        end
      endcase
    end
  end

  // group trigger response and trigger codes
  wire tr_now = in_suf && trip_w == "TR1";
  wire tr_dly = in_suf && trip_w == "TR2";
  wire go_now = (get_cmd && get_r == GET_NOW) || tr_now;
  wire go_dly = (get_cmd && get_r == GET_DELAY) || tr_dly;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dly_r <= 12'h000;
      trig_r <= 1'b0;
    end else begin
      trig_r <= go_now || dly_r == 12'h001;
      dly_r <= go_dly ? 12'(SETTLE_CYC) :
               (dly_r != 12'h000 ? dly_r - 12'h001 : dly_r);
    end
  end

  // local key pin synchroniser, remote state, bus address
  wire lk_rise = lk_s2_r && !lk_s3_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      lk_s3_r <= 1'b0;
      remote_r <= 1'b0;
      addr_r <= `BCSU_ADDR_RST;
    end else begin
      lk_s1_r <= local_key_pin;
      lk_s2_r <= lk_s1_r;
      lk_s3_r <= lk_s2_r;
      if (gtl_cmd || (lk_rise && !lockout)) begin
        remote_r <= 1'b0;
      end else if (ren_listen) begin
        remote_r <= 1'b1;
      end
      if (addr_entry_mode && fp_addr_load) begin
        addr_r <= fp_addr;
      end
    end
  end

  // talker and poll only, no controller logic exists here
  assign status_byte = {1'b0, request_service_flag, 1'b0, stat_r};
  assign srq_out = request_service_flag;
  assign ppoll_bit = request_service_flag;
  assign tx_byte = tx_r;
  assign tx_valid = tst_r == T_SEND;
  assign tx_eoi = tst_r == T_SEND && last_r;
  assign remote_mode = remote_r;
  assign bus_addr = addr_r;
  assign meas_mode = mode_r;
  assign limit_check_en = lim_r;
  assign trig_out = trig_r;
  assign cal_start = cal_go_r;
  assign cal_external = cal_ext_r;
  assign cal_value = cal_r;
  assign entry_load = ev_load_r;
  assign entry_code = pend_r;
  assign entry_value = ev_val_r;

  default clocking dcb @(posedge clk); endclocking
  default disable iff (!rst_b);
  mask_gate_a: assert property (srq_out |-> |(stat_r & mask_r[4:0]))
    else $error("request flag without enabled condition");
  sticky_bits_a: assert property (!$past(cs_p) && !$past(poll_end) |->
    (stat_r & $past(stat_r)) == $past(stat_r))
    else $error("status bit lost without clear");
  clear_status_a: assert property (cs_p && !spoll_active && ev_w == 5'h00
    && pend_ev_r == 5'h00 |=> status_byte == 8'h00 && !srq_out)
    else $error("clear code left status set");
  sm_length_a: assert property (tx_eoi && src_r == SRC_SM |->
    idx_r == 7'h16) else $error("status text not 23 chars");
  lp2_length_a: assert property (tx_eoi && src_r == SRC_LP2 |->
    idx_r == 7'h1d) else $error("binary dump not 30 bytes");
  rv_single_a: assert property (tx_valid && src_r == SRC_RV |->
    tx_eoi && tx_byte == mask_r) else $error("mask readback wrong");
  cal_range_a: assert property (cal_start |-> cal_value >= 16'h01f4 &&
    cal_value <= 16'h04b0) else $error("cal factor out of range");
  mask_store_a: assert property (in_mask |=> mask_r == $past(rx_byte))
    else $error("mask byte not stored");
  limit_gate_a: assert property ($rose(stat_r[4]) && !$past(spoll_active)
    |-> $past(lim_r) || $past(pend_ev_r[4])) else $error("limit bit ungated");
  get_now_a: assert property (get_cmd && get_r == GET_NOW |=> trig_out)
    else $error("immediate trigger missed");
  local_key_a: assert property (lk_rise && !lockout |=> !remote_mode)
    else $error("local key ignored");
  value_enter_a: assert property (entry_load |-> $past(en_p))
    else $error("value acted without enter");
endmodule : bcsu_top

// file: tb/bcsu_ctl_model.sv
// Purpose: bus controller model facing the command unit
// Assumes: one byte per clock when sending, talker read with stalls
// Notes: rx_byte idles at the inverse of the last byte, never stale
`timescale 1ns/1ns
module bcsu_ctl_model (
  input wire logic clk,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic talk_addressed,
  output logic tx_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_eoi
);
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    talk_addressed = 1'b0;
    tx_ready = 1'b1;
  end
  // sends the string as given, enter code not added; mask prefix takes a raw byte
  task automatic send(input string s, input int raw = -1);
    logic [7:0] q[$];
    foreach (s[i]) q.push_back(s[i]);
    if (raw >= 0) q.push_back(raw[7:0]);
    foreach (q[i]) begin
      @(posedge clk);
      rx_byte <= q[i];
      rx_valid <= 1'b1;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~q[q.size()-1];
  endtask : send
  // stalls at random so the talker must hold each byte
  task automatic listen(output int n, output logic [7:0] q[$]);
    q = {};
    n = 0;
    @(posedge clk);
    talk_addressed <= 1'b1;
    for (int k = 0; k < 2000 && n == 0; k++) begin
      @(posedge clk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        q.push_back(tx_byte);
        if (tx_eoi === 1'b1) n = q.size();
      end
      tx_ready <= ($urandom % 3) != 0;
    end
    talk_addressed <= 1'b0;
  endtask : listen
endmodule : bcsu_ctl_model

// file: tb/tb_top.sv
// Purpose: self-checking bench for the bus command and status unit
// Assumes: 10 MHz clk, settle count shortened to 5 cycles
// Notes: status byte is predicted by a small model kept here
`timescale 1ns/1ns
module tb_top;
  import bcsu_pkg::*;
  localparam int SETTLE = 5;
  localparam logic [95:0] ID_STR = "TESTUNIT0001"; // arbitrary value
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] rx_byte, tx_byte, status_byte;
  logic rx_valid, talk_addressed, tx_ready, tx_valid, tx_eoi;
  logic srq_out, ppoll_bit, remote_mode, limit_check_en, trig_out;
  logic cal_start, cal_external;
  logic [15:0] cal_value;
  logic [4:0] bus_addr;
  bcsu_mode_t meas_mode;
  logic get_cmd = 0, ren_listen = 0, gtl_cmd = 0, fp_addr_load = 0;
  logic spoll_active = 0, entry_load;
  logic [15:0] entry_value;
  bcsu_val_t entry_code;
  int n_ld = 0;
  logic lockout = 0, local_key_pin = 0, addr_entry_mode = 0;
  logic [4:0] fp_addr = 5'h00;
  logic data_ready_evt = 0, calzero_evt = 0, meas_err_evt = 0;
  logic limit_evt = 0;
  logic [4:0] m_stat = 5'h00;
  logic [7:0] m_mask = 8'h00;
  logic m_lim = 1'b0;
  int miscompares = 0, n_tests = 0;
  int cyc = 0, g_cyc = 0, t_cyc = 0, n_trig = 0, n_cal = 0;
  string modes[6] = '{"AP", "BP", "AD", "BD", "AR", "BR"};
  string cal_s[6] = '{"98.5", "-60", "50", "120", "49.9", "130.1"};
  int cal_v[6] = '{985, 600, 500, 1200, -1, -1};
  string tk[4] = '{"LP1", "LP2", "?ID", "SM"};
  int tl[4] = '{64, 30, 12, 23};
  always #50 clk = ~clk;
  bcsu_ctl_model ctl (.clk, .rx_byte, .rx_valid, .talk_addressed,
    .tx_ready, .tx_byte, .tx_valid, .tx_eoi);
  bcsu_top #(.SETTLE_CYC(SETTLE), .ID_TEXT(ID_STR)) i_dut (.clk, .rst_b,
    .rx_byte, .rx_valid, .talk_addressed, .tx_ready, .tx_byte, .tx_valid,
    .tx_eoi, .spoll_active, .status_byte, .srq_out, .ppoll_bit,
    .get_cmd, .ren_listen, .gtl_cmd, .lockout, .local_key_pin,
    .remote_mode, .addr_entry_mode, .fp_addr, .fp_addr_load, .bus_addr,
    .data_ready_evt, .calzero_evt, .meas_err_evt, .limit_evt, .meas_mode,
    .limit_check_en, .trig_out, .cal_start, .cal_external, .cal_value,
    .entry_load, .entry_code, .entry_value);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (get_cmd === 1'b1) g_cyc <= cyc;
    if (trig_out === 1'b1) t_cyc <= cyc;
    if (trig_out === 1'b1) n_trig <= n_trig + 1;
    if (cal_start === 1'b1) n_cal <= n_cal + 1;
    if (entry_load === 1'b1) n_ld <= n_ld + 1;
  end
  task automatic end_sim();
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w
  // one shared pulse driver so no pulse is assigned twice in a step
  task automatic pls(input logic [3:0] p);
    @(posedge clk);
    {get_cmd, ren_listen, gtl_cmd, fp_addr_load} <= p;
    @(posedge clk);
    {get_cmd, ren_listen, gtl_cmd, fp_addr_load} <= 4'h0;
    w(3);
  endtask : pls
  task automatic evt(input logic [3:0] e);
    @(posedge clk);
    {limit_evt, meas_err_evt, calzero_evt, data_ready_evt} <= e;
    @(posedge clk);
    {limit_evt, meas_err_evt, calzero_evt, data_ready_evt} <= 4'h0;
    m_stat |= {e[3] & m_lim, e[2], 1'b0, e[1], e[0]};
    w(6);
  endtask : evt
  task automatic key();
    @(posedge clk);
    local_key_pin <= 1'b1;
    w(4);
    local_key_pin <= 1'b0;
    w(5);
  endtask : key
  function automatic logic [7:0] exp_sb();
    return {1'b0, |(m_stat & m_mask[4:0]), 1'b0, m_stat};
  endfunction : exp_sb
  initial begin
    #(100 * 40000);
    miscompares++;
    end_sim();
  end
  initial begin
    int n, nb;
    logic [7:0] q[$];
    void'($urandom(32'h3103));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    w(2);
    chk(bus_addr, 13);
    chk(status_byte, 0);
    ctl.send("RV");
    ctl.listen(n, q);
    chk(n, 1);
    chk(q[0], 0);
    for (int i = 0; i < 8; i++) begin
      m_mask = $urandom;
      m_lim = i[0];
      ctl.send(m_lim ? "CSLM1@1" : "CSLM0@1", m_mask);
      m_stat = 5'h00;
      w(2);
      chk(limit_check_en, m_lim);
      evt($urandom);
      evt($urandom);
      chk(status_byte, exp_sb());
      chk(srq_out, exp_sb() >> 6);
      chk(ppoll_bit, exp_sb() >> 6);
    end
    // a serial poll freezes the byte; the buffered event lands after it
    nb = exp_sb();
    spoll_active <= 1'b1;
    evt(4'h1);
    chk(status_byte, nb);
    spoll_active <= 1'b0;
    w(2);
    m_stat = 5'h01;
    chk(status_byte, exp_sb());
    ctl.send("RV");
    ctl.listen(n, q);
    chk(q[0], m_mask);
    foreach (modes[i]) begin
      ctl.send(modes[i]);
      w(2);
      chk(meas_mode, i);
    end
    ctl.send("CS");
    ctl.send("QQ");
    w(2);
    m_stat = 5'h04;
    chk(status_byte, exp_sb());
    chk(meas_mode, 5);
    foreach (cal_s[i]) begin
      ctl.send("CS");
      nb = n_cal;
      ctl.send({"CL", cal_s[i]});
      w(3);
      chk(n_cal, nb);
      chk(entry_code, V_CL);
      ctl.send("EN");
      w(3);
      chk(status_byte[2], cal_v[i] < 0);
      chk(n_cal, nb + (cal_v[i] >= 0));
      if (cal_v[i] >= 0) chk(cal_value, cal_v[i]);
      if (cal_v[i] >= 0) chk(entry_value, cal_v[i]);
      if (cal_v[i] >= 0) chk(cal_external, i == 1);
    end
    chk(n_ld, n_cal);
    for (int i = 0; i < 3; i++) begin
      ctl.send($sformatf("GT%0d", i));
      nb = n_trig;
      pls(4'b1000);
      w(SETTLE + 10);
      chk(n_trig - nb, i != 0);
      if (i != 0) chk(t_cyc - g_cyc, i == 1 ? 1 : SETTLE + 1);
    end
    foreach (tk[i]) begin
      ctl.send(tk[i]);
      ctl.listen(n, q);
      chk(n, tl[i]);
      if (i == 2) foreach (q[k]) chk(q[k], ID_STR[95-8*k -: 8]);
      if (i == 3) chk(q[0], "S");
    end
    pls(4'b0100);
    chk(remote_mode, 1);
    key();
    chk(remote_mode, 0);
    lockout <= 1'b1;
    pls(4'b0100);
    key();
    chk(remote_mode, 1);
    pls(4'b0010);
    chk(remote_mode, 0);
    addr_entry_mode <= 1'b1;
    fp_addr <= 5'h07;
    pls(4'b0001);
    chk(bus_addr, 7);
    end_sim();
  end
endmodule : tb_top
